// [hw/pfp_pkg.sv]
// pfp_pkg: constants and types for the printer fault and panel controller.
// assumes a single 40 MHz core clock shared by every user of this package.
package pfp_pkg;

  // =========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned LOCK_TIME_MS    = 1000;
  localparam int unsigned LOCK_CYCLES     = (CLK_HZ / 1000) * LOCK_TIME_MS;
  localparam int unsigned QUICK_HALF_DEF  = 4_000_000;  // 100 ms half period
  localparam int unsigned SLOW_HALF_DEF   = 20_000_000; // 500 ms half period
  localparam int unsigned PRESS_LONG_MS   = 500;
  localparam int unsigned PRESS_LONG_CYC  = (CLK_HZ / 1000) * PRESS_LONG_MS;
  localparam int unsigned LOAD_FEED_DEF   = 64;         // lines to the outlet

  // =========================================================================
  // temperature thresholds, head sensor code in degrees celsius
  localparam logic [7:0] TEMP_HOT_C  = 8'h41;  // 65
  localparam logic [7:0] TEMP_COOL_C = 8'h3c;  // 60

  // =========================================================================
  // lamp patterns, highest severity first
  typedef enum logic [2:0] {
    PFP_PAT_NONE   = 3'b000,
    PFP_PAT_MEM    = 3'b001,
    PFP_PAT_CUT    = 3'b010,
    PFP_PAT_PEND   = 3'b011,
    PFP_PAT_COVER  = 3'b100,
    PFP_PAT_HOT    = 3'b101,
    PFP_PAT_NEAR   = 3'b110,
    PFP_PAT_MACRO  = 3'b111
  } pfp_pat_t;

  // mechanism sequencing state
  typedef enum logic [2:0] {
    PFP_ST_POR     = 3'b000,
    PFP_ST_IDLE    = 3'b001,
    PFP_ST_LOAD    = 3'b010,
    PFP_ST_LDCUT   = 3'b011,
    PFP_ST_CUTINIT = 3'b100,
    PFP_ST_SELF    = 3'b101
  } pfp_state_t;

endpackage : pfp_pkg

// [hw/pfp_ctrl.sv]
// pfp_ctrl: fault supervision and operator panel for a line thermal printer.
// assumes sensor, switch and sequencer inputs are already synchronous and
// debounced; the print engine honours print_halt and acts on the request
// pulses, answering feed_done and cut_done.
//
// Function
// R1 - power lamp is lit whenever the unit is powered, except while a memory fault blinks it.
// R2 - memory fault: power lamp quick blink, error lamp steady, never cleared.
// R3 - cover open lights error lamp and halts printing until closed.
// R4 - cover-open feed permitted when its configuration switch allows it.
// R5 - head at or above 65 C lights error lamp and suspends printing.
// R6 - printing resumes alone once the head cools to 60 C or below.
// R7 - near-end sensor lights error lamp steadily until paper is refitted.
// R8 - paper end quick-blinks error lamp and stops printing until refitted.
// R9 - paper arriving at the head starts the loading sequence automatically.
// R10 - loading pulls paper to the outlet, then cuts the excess leader.
// R11 - cutter sensor frozen one second while motor runs declares cutter lock.
// R12 - feed press during lock runs cutter initialisation, clearing the alarm.
// R13 - cutter enable switch; when disabled no cut is ever issued.
// R14 - macro wait slow-blinks error lamp; feed press starts the macro.
// R15 - brief feed press advances exactly one line.
// R16 - held feed switch keeps feeding line after line until release.
// R17 - feed held at power-on runs the self-print routine.
// R18 - blink rates programmable; highest-severity fault pattern is displayed.
`timescale 1ns/1ps

module pfp_ctrl #(
  parameter int unsigned QUICK_HALF = pfp_pkg::QUICK_HALF_DEF,
  parameter int unsigned SLOW_HALF  = pfp_pkg::SLOW_HALF_DEF,
  parameter int unsigned LOCK_CYC   = pfp_pkg::LOCK_CYCLES,
  parameter int unsigned LONG_CYC   = pfp_pkg::PRESS_LONG_CYC,
  parameter int unsigned LOAD_LINES = pfp_pkg::LOAD_FEED_DEF
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       feed_sw,
  input  wire logic       cover_open,
  input  wire logic [7:0] head_temp,
  input  wire logic       paper_near_end,
  input  wire logic       paper_present,
  input  wire logic       cutter_pos,
  input  wire logic       mem_fail,
  input  wire logic       cfg_cutter_en,
  input  wire logic       cfg_cover_feed_en,
  input  wire logic       macro_pending,
  input  wire logic       feed_done,
  input  wire logic       cut_done,
  input  wire logic       cutter_home,
  output logic            power_lamp,
  output logic            error_lamp,
  output logic            print_halt,
  output logic            feed_line_req,
  output logic            cut_req,
  output logic            cutter_motor,
  output logic            macro_start,
  output logic            self_print_start,
  output logic            cutter_lock
);
  import pfp_pkg::*;

  localparam int unsigned LCW = $clog2(LOCK_CYC + 1);
  localparam int unsigned PCW = $clog2(LONG_CYC + 1);
  localparam int unsigned QW  = $clog2(QUICK_HALF + 1);
  localparam int unsigned SW  = $clog2(SLOW_HALF + 1);
  localparam int unsigned LLW = $clog2(LOAD_LINES + 1);

  // =========================================================================
  // fault flags
  logic mem_fault_r, mem_fault_nxt;
  logic hot_r, hot_nxt;
  logic lock_r, lock_nxt;
  logic [LCW-1:0] lock_cnt_r, lock_cnt_nxt;
  logic pos_prev_r, pos_prev_nxt;
  logic init_done;

  always_comb begin
    mem_fault_nxt = mem_fault_r | mem_fail;                       // R2
    hot_nxt       = hot_r;
    if (head_temp >= TEMP_HOT_C)                                  // R5
      hot_nxt = 1'b1;
    else if (head_temp <= TEMP_COOL_C)                            // R6
      hot_nxt = 1'b0;
    pos_prev_nxt  = cutter_pos;
    lock_cnt_nxt  = '0;
    lock_nxt      = lock_r;
    // sensor must toggle while the motor turns; a frozen level means a jam
    if (cutter_motor && !lock_r && cutter_pos == pos_prev_r) begin
      lock_cnt_nxt = lock_cnt_r + LCW'(1);
      if (lock_cnt_r >= LCW'(LOCK_CYC - 1))                       // R11
        lock_nxt = 1'b1;
    end
    if (init_done)                                                // R12
      lock_nxt = 1'b0;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_fault_r <= 1'b0;
      hot_r       <= 1'b0;
      lock_r      <= 1'b0;
      lock_cnt_r  <= '0;
      pos_prev_r  <= 1'b0;
    end else begin
      mem_fault_r <= mem_fault_nxt;
      hot_r       <= hot_nxt;
      lock_r      <= lock_nxt;
      lock_cnt_r  <= lock_cnt_nxt;
      pos_prev_r  <= pos_prev_nxt;
    end
  end

  // =========================================================================
  // feed switch: press, hold and release
  logic sw_prev_r, sw_prev_nxt;
  logic [PCW-1:0] hold_cnt_r, hold_cnt_nxt;
  logic held_r, held_nxt;
  logic press;
  logic any_fault;
  logic feed_ok;

  assign press    = feed_sw & ~sw_prev_r;
  assign any_fault = mem_fault_r | lock_r | ~paper_present | hot_r
                   | cover_open;
  // feeding is mechanical only, so heat does not block it
  assign feed_ok  = !mem_fault_r && !lock_r && paper_present
                 && (!cover_open || cfg_cover_feed_en);           // R4

  always_comb begin
    sw_prev_nxt  = feed_sw;
    hold_cnt_nxt = '0;
    held_nxt     = 1'b0;
    if (feed_sw) begin
      held_nxt     = held_r;
      hold_cnt_nxt = hold_cnt_r;
      if (hold_cnt_r >= PCW'(LONG_CYC - 1))
        held_nxt = 1'b1;                                          // R16
      else
        hold_cnt_nxt = hold_cnt_r + PCW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sw_prev_r  <= 1'b0;
      hold_cnt_r <= '0;
      held_r     <= 1'b0;
    end else begin
      sw_prev_r  <= sw_prev_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      held_r     <= held_nxt;
    end
  end

  // =========================================================================
  // sequencer: power-on, paper load, cutter init, line feed
  pfp_state_t st_r, st_nxt;
  logic paper_prev_r, paper_prev_nxt;
  logic [LLW-1:0] load_cnt_r, load_cnt_nxt;
  logic busy_r, busy_nxt;          // one feed line outstanding
  logic feed_nxt, cut_nxt, motor_nxt, macro_nxt, self_nxt;

  assign init_done = (st_r == PFP_ST_CUTINIT) && cutter_home;

  always_comb begin
    st_nxt         = st_r;
    paper_prev_nxt = paper_present;
    load_cnt_nxt   = load_cnt_r;
    busy_nxt       = busy_r & ~feed_done;
    feed_nxt       = 1'b0;
    cut_nxt        = 1'b0;
    motor_nxt      = cutter_motor;
    macro_nxt      = 1'b0;
    self_nxt       = 1'b0;
    case (st_r)
      PFP_ST_POR: begin
        st_nxt = PFP_ST_IDLE;
        if (feed_sw) begin                                        // R17
          self_nxt = 1'b1;
          st_nxt   = PFP_ST_SELF;
        end
      end
      PFP_ST_SELF: begin
        if (!feed_sw)
          st_nxt = PFP_ST_IDLE;
      end
      PFP_ST_IDLE: begin
        if (paper_present && !paper_prev_r && !mem_fault_r) begin // R9
          st_nxt       = PFP_ST_LOAD;
          load_cnt_nxt = '0;
        end else if (lock_r && press) begin                       // R12
          st_nxt    = PFP_ST_CUTINIT;
          motor_nxt = 1'b1;
        end else if (macro_pending && press && !any_fault) begin  // R14
          macro_nxt = 1'b1;
        end else if (feed_ok && !busy_r && (press || held_r)) begin
          feed_nxt = 1'b1;                                        // R15 R16
          busy_nxt = 1'b1;
        end
      end
      PFP_ST_LOAD: begin
        if (!paper_present || mem_fault_r) begin
          st_nxt = PFP_ST_IDLE;
        end else if (!busy_r && load_cnt_r >= LLW'(LOAD_LINES)) begin // R10
          if (cfg_cutter_en && !lock_r) begin                     // R13
            st_nxt    = PFP_ST_LDCUT;
            cut_nxt   = 1'b1;
            motor_nxt = 1'b1;
          end else begin
            st_nxt = PFP_ST_IDLE;
          end
        end else if (!busy_r) begin
          feed_nxt     = 1'b1;
          busy_nxt     = 1'b1;
          load_cnt_nxt = load_cnt_r + LLW'(1);
        end
      end
      PFP_ST_LDCUT: begin
        if (cut_done || lock_r) begin                             // R11
          motor_nxt = 1'b0;
          st_nxt    = PFP_ST_IDLE;
        end
      end
      PFP_ST_CUTINIT: begin
        if (cutter_home) begin
          motor_nxt = 1'b0;
          st_nxt    = PFP_ST_IDLE;
        end
      end
      default: st_nxt = PFP_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r             <= PFP_ST_POR;
      paper_prev_r     <= 1'b0;
      load_cnt_r       <= '0;
      busy_r           <= 1'b0;
      feed_line_req    <= 1'b0;
      cut_req          <= 1'b0;
      cutter_motor     <= 1'b0;
      macro_start      <= 1'b0;
      self_print_start <= 1'b0;
    end else begin
      st_r             <= st_nxt;
      paper_prev_r     <= paper_prev_nxt;
      load_cnt_r       <= load_cnt_nxt;
      busy_r           <= busy_nxt;
      feed_line_req    <= feed_nxt;
      cut_req          <= cut_nxt;
      cutter_motor     <= motor_nxt;
      macro_start      <= macro_nxt;
      self_print_start <= self_nxt;
    end
  end

  // =========================================================================
  // lamps and halt
  logic [QW-1:0] q_cnt_r, q_cnt_nxt;
  logic [SW-1:0] s_cnt_r, s_cnt_nxt;
  logic q_ph_r, q_ph_nxt, s_ph_r, s_ph_nxt;
  pfp_pat_t pat;
  logic pwr_nxt, err_nxt, halt_nxt;

  always_comb begin
    q_cnt_nxt = q_cnt_r + QW'(1);
    q_ph_nxt  = q_ph_r;
    if (q_cnt_r >= QW'(QUICK_HALF - 1)) begin                     // R18
      q_cnt_nxt = '0;
      q_ph_nxt  = ~q_ph_r;
    end
    s_cnt_nxt = s_cnt_r + SW'(1);
    s_ph_nxt  = s_ph_r;
    if (s_cnt_r >= SW'(SLOW_HALF - 1)) begin
      s_cnt_nxt = '0;
      s_ph_nxt  = ~s_ph_r;
    end
    // priority chain, most severe first
    if (mem_fault_r)              pat = PFP_PAT_MEM;              // R18
    else if (lock_r)              pat = PFP_PAT_CUT;
    else if (!paper_present)      pat = PFP_PAT_PEND;
    else if (cover_open)          pat = PFP_PAT_COVER;
    else if (hot_r)               pat = PFP_PAT_HOT;
    else if (paper_near_end)      pat = PFP_PAT_NEAR;
    else if (macro_pending)       pat = PFP_PAT_MACRO;
    else                          pat = PFP_PAT_NONE;
    pwr_nxt = 1'b1;                                               // R1
    err_nxt = 1'b0;
    case (pat)
      PFP_PAT_MEM: begin
        pwr_nxt = q_ph_r;                                         // R2
        err_nxt = 1'b1;
      end
      PFP_PAT_CUT:   err_nxt = q_ph_r & s_ph_r;                   // R11
      PFP_PAT_PEND:  err_nxt = q_ph_r;                            // R8
      PFP_PAT_COVER: err_nxt = 1'b1;                              // R3
      PFP_PAT_HOT:   err_nxt = 1'b1;                              // R5
      PFP_PAT_NEAR:  err_nxt = 1'b1;                              // R7
      PFP_PAT_MACRO: err_nxt = s_ph_r;                            // R14
      default:       err_nxt = 1'b0;
    endcase
    halt_nxt = any_fault;                                         // R3 R8
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q_cnt_r     <= '0;
      s_cnt_r     <= '0;
      q_ph_r      <= 1'b0;
      s_ph_r      <= 1'b0;
      power_lamp  <= 1'b0;
      error_lamp  <= 1'b0;
      print_halt  <= 1'b1;
      cutter_lock <= 1'b0;
    end else begin
      q_cnt_r     <= q_cnt_nxt;
      s_cnt_r     <= s_cnt_nxt;
      q_ph_r      <= q_ph_nxt;
      s_ph_r      <= s_ph_nxt;
      power_lamp  <= pwr_nxt;
      error_lamp  <= err_nxt;
      print_halt  <= halt_nxt;
      cutter_lock <= lock_nxt;
    end
  end

endmodule : pfp_ctrl

// [test/pfp_ctrl_asserts.sv]
// pfp_ctrl_asserts: port-level checks for pfp_ctrl.
// assumes it is bound to every pfp_ctrl and sees only its ports.
`timescale 1ns/1ps
module pfp_ctrl_asserts #(
  parameter int unsigned LOCK_CYC = 20
) (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       feed_sw,
  input wire logic       cover_open,
  input wire logic [7:0] head_temp,
  input wire logic       paper_present,
  input wire logic       cutter_pos,
  input wire logic       mem_fail,
  input wire logic       cfg_cutter_en,
  input wire logic       macro_pending,
  input wire logic       feed_done,
  input wire logic       power_lamp,
  input wire logic       error_lamp,
  input wire logic       print_halt,
  input wire logic       feed_line_req,
  input wire logic       cut_req,
  input wire logic       cutter_motor,
  input wire logic       macro_start,
  input wire logic       self_print_start,
  input wire logic       cutter_lock
);
  logic        mem_r;
  logic        pos_r;
  logic [2:0]  cyc_r;
  int unsigned frz_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ======
  // helpers: fault latch, cycles since reset, frozen-sensor count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_r <= 1'b0;
      pos_r <= 1'b0;
      cyc_r <= 3'h0;
      frz_r <= 0;
    end else begin
      mem_r <= mem_r | mem_fail;
      pos_r <= cutter_pos;
      cyc_r <= (cyc_r == 3'h7) ? cyc_r : cyc_r + 3'h1;
      frz_r <= (cutter_motor && cutter_pos == pos_r) ? frz_r + 1 : 0;
    end
  end
  // ======
  // assertions
  AST_PWR_ON: assert property (cyc_r == 3'h7 && !mem_r |-> power_lamp)
    else $error("power lamp dark");
  AST_MEM_HOLD: assert property (mem_r |=> error_lamp && print_halt)
    else $error("memory fault not shown");
  AST_COVER_HALT: assert property (cover_open [*2] |-> print_halt)
    else $error("cover open without halt");
  // the overheat flag is itself registered, so halt trails by two edges
  AST_HOT_HALT: assert property (
    (head_temp >= pfp_pkg::TEMP_HOT_C) [*3] |-> print_halt)
    else $error("hot head without halt");
  AST_PEND_HALT: assert property (!paper_present [*2] |-> print_halt)
    else $error("paper end without halt");
  AST_LOCK_DET: assert property (
    frz_r == LOCK_CYC |-> ##[0:3] cutter_lock)
    else $error("cutter lock missed");
  AST_LOCK_HALT: assert property (
    $rose(cutter_lock) |-> ##[0:1] print_halt)
    else $error("lock without halt");
  AST_LOCK_STOP: assert property (
    $rose(cutter_lock) |-> ##[0:1] !cutter_motor)
    else $error("cutter motor runs on after lock");
  AST_NO_CUT: assert property (!cfg_cutter_en [*2] |-> !cut_req)
    else $error("cut while cutter disabled");
  // a press is a rising edge of the switch, not a held level
  AST_MACRO_PRESS: assert property (
    macro_start |-> $past(macro_pending) && $past(feed_sw)
      && !$past(feed_sw, 2))
    else $error("macro start without press");
  AST_FEED_ONE: assert property (
    feed_line_req |=> !feed_line_req until feed_done)
    else $error("second feed before done");
  AST_SELF_EARLY: assert property (self_print_start |-> cyc_r <= 3'h4)
    else $error("self print late");
  C_FEED: cover property (feed_line_req);
  C_CUT: cover property (cut_req);
  C_LOCK: cover property (cutter_lock);
  C_MACRO: cover property (macro_start);
endmodule : pfp_ctrl_asserts

bind pfp_ctrl pfp_ctrl_asserts #(.LOCK_CYC(LOCK_CYC)) u_chk (.core_clk,
  .resetn, .feed_sw, .cover_open, .head_temp, .paper_present, .cutter_pos,
  .mem_fail, .cfg_cutter_en, .macro_pending, .feed_done, .power_lamp,
  .error_lamp, .print_halt, .feed_line_req, .cut_req, .cutter_motor,
  .macro_start, .self_print_start, .cutter_lock);

// [test/pfp_mech_model.sv]
// pfp_mech_model: print engine and cutter mechanism behind pfp_ctrl.
// assumes the bench raises jam to freeze the cutter sensor.
`timescale 1ns/1ps
module pfp_mech_model (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic jam,
  input  wire logic feed_line_req,
  input  wire logic cut_req,
  input  wire logic cutter_motor,
  output logic      feed_done,
  output logic      cut_done,
  output logic      cutter_pos,
  output logic      cutter_home
);
  logic [1:0] fd_r;
  logic [2:0] ct_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fd_r        <= 2'h0;
      ct_r        <= 3'h0;
      feed_done   <= 1'b0;
      cut_done    <= 1'b0;
      cutter_pos  <= 1'b0;
      cutter_home <= 1'b1;
    end else begin
      // each line answered once, three cycles late
      fd_r      <= {fd_r[0], feed_line_req};
      feed_done <= fd_r[1];
      cut_done  <= 1'b0;
      if (cut_req)
        cutter_home <= 1'b0;
      // a jammed blade leaves the position sensor frozen
      if (cutter_motor && !jam) begin
        ct_r       <= ct_r + 3'h1;
        cutter_pos <= ct_r[1];
        if (ct_r == 3'h7) begin
          cut_done    <= 1'b1;
          cutter_home <= 1'b1;
        end
      end else
        ct_r <= 3'h0;
    end
  end
endmodule : pfp_mech_model

// [test/printer_fault_panel_ctrl_tb.sv]
// printer_fault_panel_ctrl_tb: self-checking bench for pfp_ctrl.
// assumes pfp_mech_model answers feeds and cuts; short test counts.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module printer_fault_panel_ctrl_tb;
  logic core_clk, resetn, feed_sw, cover_open, paper_near_end, paper_present;
  logic mem_fail, cfg_cutter_en, cfg_cover_feed_en, macro_pending, jam;
  logic feed_done, cut_done, cutter_pos, cutter_home, power_lamp, error_lamp;
  logic print_halt, feed_line_req, cut_req, cutter_motor, macro_start;
  logic self_print_start, cutter_lock, er_q, pw_q;
  logic [7:0] head_temp;
  int bad_count, checks_done, cyc, n_feed, n_cut, n_mac, n_self, n_er, n_pw;
  pfp_ctrl #(.QUICK_HALF(4), .SLOW_HALF(16), .LOCK_CYC(20), .LONG_CYC(8),
    .LOAD_LINES(3)) dut (.core_clk, .resetn, .feed_sw, .cover_open,
    .head_temp, .paper_near_end, .paper_present, .cutter_pos, .mem_fail,
    .cfg_cutter_en, .cfg_cover_feed_en, .macro_pending, .feed_done,
    .cut_done, .cutter_home, .power_lamp, .error_lamp, .print_halt,
    .feed_line_req, .cut_req, .cutter_motor, .macro_start,
    .self_print_start, .cutter_lock);
  pfp_mech_model u_mech (.core_clk, .resetn, .jam, .feed_line_req, .cut_req,
    .cutter_motor, .feed_done, .cut_done, .cutter_pos, .cutter_home);
  always #12.5 core_clk = ~core_clk;
  // ======
  // pulse and blink counters
  always @(posedge core_clk) begin
    cyc++;
    if (feed_line_req) n_feed++;
    if (cut_req) n_cut++;
    if (macro_start) n_mac++;
    if (self_print_start) n_self++;
    if (error_lamp !== er_q) n_er++;
    if (power_lamp !== pw_q) n_pw++;
    er_q = error_lamp;
    pw_q = power_lamp;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic press(input int n);
    feed_sw = 1'b1;
    tick(n);
    feed_sw = 1'b0;
  endtask : press
  task automatic clr();
    {n_feed, n_cut, n_mac, n_self, n_er, n_pw} = '0;
  endtask : clr
  // ======
  // scenarios
  task automatic t_feed();
    clr();
    press(2);
    tick(20);
    `CHK("brief", 1, n_feed)
    press(40);
    tick(20);
    `CHK("hold", 1'b1, n_feed > 3)
    clr();
    tick(20);
    `CHK("released", 0, n_feed)
  endtask : t_feed
  task automatic t_cover();
    cover_open = 1'b1;
    tick(4);
    `CHK("cover halt", 1'b1, print_halt)
    `CHK("cover lamp", 1'b1, error_lamp)
    clr();
    press(2);
    tick(10);
    `CHK("cover refuse", 0, n_feed)
    cfg_cover_feed_en = 1'b1;
    press(2);
    tick(10);
    `CHK("cover feed", 1, n_feed)
    {cover_open, cfg_cover_feed_en} = 2'b00;
    tick(4);
    `CHK("closed", 1'b0, print_halt | error_lamp)
  endtask : t_cover
  task automatic t_temp();
    head_temp = 8'h41;
    tick(4);
    `CHK("hot", 1'b1, print_halt & error_lamp)
    head_temp = 8'h3d;
    tick(4);
    `CHK("cooling", 1'b1, print_halt)
    head_temp = 8'h3c;
    tick(4);
    `CHK("cooled", 1'b0, print_halt)
    paper_near_end = 1'b1;
    tick(4);
    `CHK("near", 2'b10, {error_lamp, print_halt})
    paper_near_end = 1'b0;
    tick(4);
    `CHK("refit", 1'b0, error_lamp)
  endtask : t_temp
  task automatic t_load(input logic cut, input logic stuck);
    {cfg_cutter_en, jam, paper_present} = {cut, stuck, 1'b0};
    tick(4);
    clr();
    tick(20);
    `CHK("end halt", 1'b1, print_halt)
    `CHK("quick", 1'b1, n_er >= 4 && n_er <= 6)
    clr();
    paper_present = 1'b1;
    tick(70);
    `CHK("load lines", 3, n_feed)
    `CHK("load cut", int'(cut), n_cut)
    `CHK("lock", stuck, cutter_lock)
    `CHK("lock halt", stuck, print_halt)
    `CHK("motor stop", 1'b0, cutter_motor)
    jam = 1'b0;
    if (stuck) press(2);
    tick(30);
    `CHK("unlocked", 1'b0, cutter_lock | print_halt)
    `CHK("blade home", 1'b0, cutter_motor)
  endtask : t_load
  task automatic t_macro();
    macro_pending = 1'b1;
    tick(2);
    clr();
    tick(64);
    `CHK("slow", 1'b1, n_er >= 3 && n_er <= 5)
    paper_near_end = 1'b1;
    tick(4);
    clr();
    tick(40);
    `CHK("priority", 0, n_er)
    paper_near_end = 1'b0;
    tick(4);
    press(2);
    tick(4);
    `CHK("macro", 1, n_mac)
    macro_pending = 1'b0;
  endtask : t_macro
  task automatic t_mem();
    mem_fail = 1'b1;
    tick(1);
    mem_fail = 1'b0;
    tick(4);
    clr();
    press(2);
    tick(40);
    `CHK("mem lamp", 1'b1, error_lamp)
    `CHK("mem blink", 1'b1, n_pw >= 9 && n_pw <= 11)
    `CHK("mem refuse", 0, n_feed)
  endtask : t_mem
  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    {core_clk, resetn, cover_open, paper_near_end, mem_fail} = '0;
    {cfg_cover_feed_en, macro_pending, jam} = '0;
    {feed_sw, paper_present, cfg_cutter_en} = 3'b111;
    head_temp = 8'h19;
    tick(6);
    resetn = 1'b1;
    tick(3);
    feed_sw = 1'b0;
    tick(10);
    `CHK("self print", 1, n_self)
    `CHK("power", 1'b1, power_lamp)
    t_feed();
    t_cover();
    t_temp();
    t_load(1'b1, 1'b0);
    t_load(1'b0, 1'b0);
    t_load(1'b1, 1'b1);
    t_macro();
    t_mem();
    give_verdict();
  end
endmodule : printer_fault_panel_ctrl_tb
